//--- sac_pkg.sv
package sac_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the plain register port).
    // ------------------------------------------------------------------
    localparam logic [7:0] SAC_ADDR_CONTROL = 8'h26;
    localparam logic [7:0] SAC_ADDR_TIMING = 8'h27;
    localparam logic [7:0] SAC_ADDR_RES_LOW = 8'h28;
    localparam logic [7:0] SAC_ADDR_RES_HIGH = 8'h29;

    // Values after reset and after deep standby.
    localparam logic [7:0] SAC_CONTROL_RESET = 8'h10;
    localparam logic [5:0] SAC_TIMING_RESET = 6'h10;

    // Field positions in conversion_control.
    localparam int SAC_CTL_START_BIT = 7;
    localparam int SAC_CTL_MODE_LSB = 5;
    localparam int SAC_CTL_AIN_DIS_BIT = 4;
    localparam int SAC_CTL_CHAN_LSB = 0;

    // Field positions in conversion_timing.
    localparam int SAC_TIM_LADDER_BIT = 5;
    localparam int SAC_TIM_TIME_LSB = 1;

    // Field positions in result_low_status.
    localparam int SAC_LOW_DONE_BIT = 5;
    localparam int SAC_LOW_BUSY_BIT = 4;

    // Operating modes of the two-bit mode field.
    typedef enum logic [1:0] {
        SAC_MODE_OFF = 2'h0,
        SAC_MODE_SOFTWARE = 2'h1,
        SAC_MODE_RESERVED = 2'h2,
        SAC_MODE_REPEAT = 2'h3
    } sac_mode_e;

    // Conversion lengths in main clock periods, and the step count of one
    // conversion: three sampling steps plus ten bit decisions.
    localparam int SAC_CONV_39 = 39;
    localparam int SAC_CONV_78 = 78;
    localparam int SAC_CONV_156 = 156;
    localparam int SAC_CONV_312 = 312;
    localparam int SAC_CONV_624 = 624;
    localparam int SAC_CONV_1248 = 1248;
    localparam int SAC_SAR_STEPS = 13;
    localparam int SAC_SAMPLE_STEPS = 3;
    localparam int SAC_STEP_W = 7;
    localparam int SAC_RES_W = 10;

    // Cycles in which a start cannot act after control is written with zero.
    localparam logic [2:0] SAC_ZERO_GUARD_CYCLES = 3'h4;

endpackage : sac_pkg

//--- sac_sar_if.sv
`timescale 1ns/1ps
`default_nettype none

// Link between the control registers and the approximation sequencer.
interface sac_sar_if;
    import sac_pkg::*;
    logic start;
    logic abort;
    logic [SAC_STEP_W-1:0] step_len;
    logic comp_hi;
    logic busy;
    logic done;
    logic sampling;
    logic [SAC_RES_W-1:0] result;
    logic [SAC_RES_W-1:0] trial_code;

    modport ctrl (
        output start,
        output abort,
        output step_len,
        output comp_hi,
        input busy,
        input done,
        input sampling,
        input result,
        input trial_code
    );

    modport eng (
        input start,
        input abort,
        input step_len,
        input comp_hi,
        output busy,
        output done,
        output sampling,
        output result,
        output trial_code
    );
endinterface : sac_sar_if

`default_nettype wire

//--- sac_sar_engine.sv
`timescale 1ns/1ps
`default_nettype none

module sac_sar_engine
    import sac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    sac_sar_if.eng sar
);

    typedef enum logic [1:0] {
        SAC_ST_IDLE = 2'b00,
        SAC_ST_SAMPLE = 2'b01,
        SAC_ST_CONVERT = 2'b11
    } sac_state_e;

    sac_state_e state_q;
    logic [SAC_STEP_W-1:0] cyc_q;
    logic [3:0] step_q;
    logic [SAC_RES_W-1:0] sar_q;
    logic [SAC_RES_W-1:0] result_q;
    logic done_q;
    logic step_end;
    logic last_step;
    logic [3:0] bit_pos;

    // Step bookkeeping; bit positions count down from the top bit.
    assign step_end = (cyc_q == sar.step_len - 7'd1);
    assign last_step = (step_q == 4'(SAC_SAR_STEPS - 1));
    assign bit_pos = 4'(SAC_SAR_STEPS - 1) - step_q;

    // ------------------------------------------------------------------
    // Sequencer: sample, then one comparison per result bit.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst || sar.abort) begin
            state_q <= SAC_ST_IDLE;
            cyc_q <= '0;
            step_q <= '0;
            sar_q <= '0;
        end else begin
            case (state_q)
                SAC_ST_IDLE: begin
                    if (sar.start) begin
                        state_q <= SAC_ST_SAMPLE;
                        cyc_q <= '0;
                        step_q <= '0;
                        sar_q <= '0;
                    end
                end
                SAC_ST_SAMPLE, SAC_ST_CONVERT: begin
                    cyc_q <= step_end ? '0 : cyc_q + 7'd1;
                    if (step_end) begin
                        // The comparator is judged only at the end of a step,
                        // so the trial level has settled for the whole step.
                        if (state_q == SAC_ST_CONVERT && !sar.comp_hi) begin
                            sar_q[bit_pos] <= 1'b0;
                        end
                        if (last_step) begin
                            state_q <= SAC_ST_IDLE;
                        end else begin
                            step_q <= step_q + 4'd1;
                            if (step_q == 4'(SAC_SAMPLE_STEPS - 1)) begin
                                state_q <= SAC_ST_CONVERT;
                            end
                            if (step_q >= 4'(SAC_SAMPLE_STEPS - 1)) begin
                                sar_q[bit_pos - 4'd1] <= 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= SAC_ST_IDLE;
                end
            endcase
        end
    end

    // Result and completion pulse leave together; an abort stores nothing.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!sar.abort && state_q == SAC_ST_CONVERT && step_end && last_step) begin
                result_q <= sar.comp_hi ? sar_q : (sar_q & 10'h3fe);
                done_q <= 1'b1;
            end
        end
    end

    assign sar.busy = (state_q != SAC_ST_IDLE);
    assign sar.sampling = (state_q == SAC_ST_SAMPLE);
    assign sar.done = done_q;
    assign sar.result = result_q;
    assign sar.trial_code = sar_q;

endmodule : sac_sar_engine

`default_nettype wire

//--- sac_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Mode field: off, software start, repeat
// - Analog input path enabled when disable is zero
// - Channel codes 0..7 route inputs; others reserved
// - Start bit self-clears once conversion begins
// - Deep standby forces controls to reset, blocks writes
// - Four cycles no start after zero control write
// - Ladder on during conversion, or always if set
// - Timing code selects 39 to 1248 clock periods
// - Timing top two bits read without defined value
// - Done flag high after conversion; cleared at start, except at a start in a completion cycle
// - Reading upper result clears done flag
// - Busy high while converting; cleared by standby
// - Low status bits three to zero undefined
// - Ten-bit successive approximation, one bit per step
// - Low register: two result bits, done, busy
// - Completion stores result, sets done, raises irq together
// - Repeat mode restarts automatically after each completion
// - Mode off stops at once, nothing stored
// - No automatic restart after deep standby
module sac_top
    import sac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic deep_standby,
    input wire logic comparator_in,
    output logic sample_hold_en,
    output logic [9:0] dac_code,
    output logic ladder_connect,
    output logic analog_in_enable,
    output logic [7:0] analog_route,
    output logic conv_busy_flag,
    output logic conv_done_irq
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    sac_sar_if sar ();

    logic [7:0] control_q;
    logic [5:0] timing_q;
    logic conv_done_flag_q;
    logic [2:0] guard_q;
    logic comp_meta_q;
    logic comp_sync_q;
    logic [7:0] rdata_q;
    logic [7:0] route_q;
    logic ladder_q;
    logic ain_en_q;

    logic wr_control;
    logic wr_timing;
    logic rd_high;
    logic conv_start_bit;
    logic analog_in_disable;
    logic ladder_keep_on;
    logic [3:0] channel_select;
    logic [2:0] time_code;
    sac_mode_e op_mode_field;
    logic mode_active;
    logic stop_now;
    logic start_go;
    logic repeat_go;

    // ------------------------------------------------------------------
    // Decode of conversion-time codes into cycles per approximation step.
    // ------------------------------------------------------------------

    // Each conversion is 13 equal steps, so every legal length divides
    // exactly. Reserved codes fall back to the slowest, safest setting.
    function automatic logic [SAC_STEP_W-1:0] step_cycles(input logic [2:0] code);
        logic [SAC_STEP_W-1:0] len;
        len = SAC_STEP_W'(SAC_CONV_1248 / SAC_SAR_STEPS);
        case (code)
            3'h0: len = SAC_STEP_W'(SAC_CONV_39 / SAC_SAR_STEPS);
            3'h2: len = SAC_STEP_W'(SAC_CONV_78 / SAC_SAR_STEPS);
            3'h3: len = SAC_STEP_W'(SAC_CONV_156 / SAC_SAR_STEPS);
            3'h4: len = SAC_STEP_W'(SAC_CONV_312 / SAC_SAR_STEPS);
            3'h5: len = SAC_STEP_W'(SAC_CONV_624 / SAC_SAR_STEPS);
            3'h6: len = SAC_STEP_W'(SAC_CONV_1248 / SAC_SAR_STEPS);
            default: len = SAC_STEP_W'(SAC_CONV_1248 / SAC_SAR_STEPS);
        endcase
        return len;
    endfunction : step_cycles

    // ------------------------------------------------------------------
    // Field views of the control registers.
    // ------------------------------------------------------------------

    // Named views keep the decode below readable.
    assign conv_start_bit = control_q[SAC_CTL_START_BIT];
    assign op_mode_field = sac_mode_e'(control_q[SAC_CTL_MODE_LSB +: 2]);
    assign analog_in_disable = control_q[SAC_CTL_AIN_DIS_BIT];
    assign channel_select = control_q[SAC_CTL_CHAN_LSB +: 4];
    assign ladder_keep_on = timing_q[SAC_TIM_LADDER_BIT];
    assign time_code = timing_q[SAC_TIM_TIME_LSB +: 3];

    // The reserved mode code is treated as disabled so it can never
    // launch a conversion.
    assign mode_active = (op_mode_field == SAC_MODE_SOFTWARE) ||
                         (op_mode_field == SAC_MODE_REPEAT);

    // ------------------------------------------------------------------
    // Register port decode.
    // ------------------------------------------------------------------

    // Writes are dropped entirely while deep standby holds the block.
    assign wr_control = reg_wr && (reg_addr == SAC_ADDR_CONTROL) && !deep_standby;
    assign wr_timing = reg_wr && (reg_addr == SAC_ADDR_TIMING) && !deep_standby;
    assign rd_high = reg_rd && (reg_addr == SAC_ADDR_RES_HIGH);

    // ------------------------------------------------------------------
    // Control register.
    // ------------------------------------------------------------------

    // Standby restores the reset value and the mode then reads off, so
    // nothing restarts by itself on return.
    always_ff @(posedge ref_clk) begin
        if (rst || deep_standby) begin
            control_q <= SAC_CONTROL_RESET;
        end else if (wr_control) begin
            control_q <= reg_wdata;
        end else if (start_go) begin
            control_q[SAC_CTL_START_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Timing register.
    // ------------------------------------------------------------------

    // Only six bits are kept; the two top positions have no storage.
    always_ff @(posedge ref_clk) begin
        if (rst || deep_standby) begin
            timing_q <= SAC_TIMING_RESET;
        end else if (wr_timing) begin
            timing_q <= reg_wdata[5:0];
        end
    end

    // ------------------------------------------------------------------
    // Start guard after a zero control write.
    // ------------------------------------------------------------------

    // A start written during the guard stays pending and acts afterwards.
    always_ff @(posedge ref_clk) begin
        if (rst || deep_standby) begin
            guard_q <= '0;
        end else if (wr_control && reg_wdata == 8'h00) begin
            guard_q <= SAC_ZERO_GUARD_CYCLES;
        end else if (guard_q != 3'h0) begin
            guard_q <= guard_q - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Start, repeat and stop decisions.
    // ------------------------------------------------------------------

    // Software start: the sequencer must be idle. Software is expected
    // not to raise the start bit again while busy; if it does, the bit
    // simply waits until the running conversion ends.
    assign start_go = conv_start_bit && mode_active && (guard_q == 3'h0) &&
                      !sar.busy && !deep_standby && !wr_control;

    // Repeat mode relaunches in the completion cycle itself, on the same
    // channel, so busy drops for exactly one cycle between conversions.
    assign repeat_go = sar.done && (op_mode_field == SAC_MODE_REPEAT) &&
                       !sar.busy;

    // Writing the disable code takes effect in the write cycle itself, so
    // a completion due in that very cycle is suppressed as well.
    assign stop_now = deep_standby || !mode_active ||
                      (wr_control && reg_wdata[SAC_CTL_MODE_LSB +: 2] == SAC_MODE_OFF) ||
                      (wr_control && reg_wdata[SAC_CTL_MODE_LSB +: 2] == SAC_MODE_RESERVED);

    assign sar.start = (start_go || repeat_go) && !stop_now;
    assign sar.abort = stop_now;
    assign sar.step_len = step_cycles(time_code);
    assign sar.comp_hi = comp_sync_q;

    // ------------------------------------------------------------------
    // Comparator synchroniser.
    // ------------------------------------------------------------------

    // The comparator settles asynchronously to the clock; two flops
    // guard against metastability. Each step is at least three cycles,
    // so the two-cycle lag still sees the settled decision.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            comp_meta_q <= 1'b0;
            comp_sync_q <= 1'b0;
        end else begin
            comp_meta_q <= comparator_in;
            comp_sync_q <= comp_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Approximation sequencer.
    // ------------------------------------------------------------------
    sac_sar_engine sac_sar_engine_inst (
        .ref_clk(ref_clk),
        .rst(rst),
        .sar(sar.eng)
    );

    // ------------------------------------------------------------------
    // Done flag.
    // ------------------------------------------------------------------

    // Completion has priority over both clears, so a result that lands in
    // the same cycle as an upper-byte read is never lost.
    always_ff @(posedge ref_clk) begin
        if (rst || deep_standby) begin
            conv_done_flag_q <= 1'b0;
        end else if (sar.done) begin
            conv_done_flag_q <= 1'b1;
        end else if (sar.start) begin
            conv_done_flag_q <= 1'b0;
        end else if (rd_high) begin
            conv_done_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Completion pulse.
    // ------------------------------------------------------------------

    // The engine's registered done pulse is used as is; a further flop
    // would let the pulse trail the stored result by one cycle.
    assign conv_done_irq = sar.done;

    // ------------------------------------------------------------------
    // Analog-side controls.
    // ------------------------------------------------------------------

    // Reserved channel codes and a disabled input path route nothing.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            route_q <= '0;
            ain_en_q <= 1'b0;
            ladder_q <= 1'b0;
        end else begin
            route_q <= '0;
            if (!channel_select[3] && !analog_in_disable) begin
                route_q[channel_select[2:0]] <= 1'b1;
            end
            ain_en_q <= !analog_in_disable;
            ladder_q <= ladder_keep_on || sar.busy || sar.start;
        end
    end

    // ------------------------------------------------------------------
    // Read data, one cycle after the read strobe.
    // ------------------------------------------------------------------

    // Undefined positions read as zero; unmapped addresses read zero.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                SAC_ADDR_CONTROL: rdata_q <= control_q;
                SAC_ADDR_TIMING: rdata_q <= {2'b00, timing_q};
                // The done pulse is folded in so the flag shows with the result.
                SAC_ADDR_RES_LOW: rdata_q <= {sar.result[1:0], conv_done_flag_q || sar.done,
                                              sar.busy, 4'h0};
                SAC_ADDR_RES_HIGH: rdata_q <= sar.result[9:2];
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign sample_hold_en = sar.sampling;
    assign dac_code = sar.trial_code;
    assign ladder_connect = ladder_q;
    assign analog_in_enable = ain_en_q;
    assign analog_route = route_q;
    assign conv_busy_flag = sar.busy;

endmodule : sac_top

`default_nettype wire

//--- sac_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port-level checks of the converter control block.
// ----------------------------------------------------------------
module sac_top_monitor
    import sac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic deep_standby,
    input wire logic sample_hold_en,
    input wire logic ladder_connect,
    input wire logic analog_in_enable,
    input wire logic [7:0] analog_route,
    input wire logic conv_busy_flag,
    input wire logic conv_done_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic ctl_wr;
    // A control write that standby does not swallow.
    assign ctl_wr = reg_wr && reg_addr == SAC_ADDR_CONTROL && !deep_standby;

    chk_irq_at_end: assert property (conv_done_irq |-> $fell(conv_busy_flag))
        else $error("irq without end of conversion");
    chk_irq_one_cycle: assert property (conv_done_irq |=> !conv_done_irq)
        else $error("irq longer than one cycle");
    chk_standby_stops: assert property (deep_standby |=> !conv_busy_flag)
        else $error("busy during standby");
    chk_no_self_restart: assert property ($fell(deep_standby) && !reg_wr |->
        !conv_busy_flag ##1 !conv_busy_flag)
        else $error("restart after standby");
    // Mode codes 00 and 10 both have a low bit of zero and stop the engine.
    chk_off_aborts: assert property (ctl_wr && !reg_wdata[SAC_CTL_MODE_LSB] |=>
        !conv_busy_flag ##1 (!conv_busy_flag && !conv_done_irq))
        else $error("off mode did not abort");
    chk_zero_guard: assert property (ctl_wr && reg_wdata == 8'h00 |=>
        !conv_busy_flag [*4])
        else $error("start inside guard");
    chk_ladder_in_conv: assert property (conv_busy_flag |-> ladder_connect)
        else $error("ladder off while busy");
    chk_route_single: assert property ($onehot0(analog_route))
        else $error("more than one input routed");
    chk_route_when_off: assert property (!analog_in_enable |-> analog_route == 8'h00)
        else $error("route while input disabled");
    chk_status_busy: assert property (reg_rd && reg_addr == SAC_ADDR_RES_LOW |=>
        reg_rdata[SAC_LOW_BUSY_BIT] == $past(conv_busy_flag) && reg_rdata[3:0] == 4'h0)
        else $error("status byte wrong");
    chk_sample_in_conv: assert property (sample_hold_en |-> conv_busy_flag)
        else $error("sampling while idle");
endmodule : sac_top_monitor

bind sac_top sac_top_monitor sac_top_monitor_inst (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .deep_standby, .sample_hold_en, .ladder_connect,
    .analog_in_enable, .analog_route, .conv_busy_flag, .conv_done_irq);
`default_nettype wire

//--- sac_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural sample-hold, comparator and ladder on the far side.
module sac_analog_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_hold_en,
    input wire logic [7:0] analog_route,
    input wire logic [9:0] dac_code,
    input wire logic [7:0][9:0] levels,
    output logic comparator_in
);
    logic [9:0] held_q;
    // The hold node tracks the routed input only while sampling; with
    // nothing routed it drains to ground, as a real capacitor would.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            held_q <= 10'h000;
        end else if (sample_hold_en) begin
            held_q <= 10'h000;
            for (int c = 0; c < 8; c++) begin
                if (analog_route[c]) begin
                    held_q <= levels[c];
                end
            end
        end
    end
    // High while the held input is at or above the trial code.
    assign comparator_in = (held_q >= dac_code);
endmodule : sac_analog_model
`default_nettype wire

//--- test_sar_adc_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (a), (e)); end end
module test_sar_adc_control;
    import sac_pkg::*;
    logic ref_clk, rst, reg_wr, reg_rd, deep_standby, comparator_in, sample_hold_en;
    logic ladder_connect, analog_in_enable, conv_busy_flag, conv_done_irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, analog_route;
    logic [9:0] dac_code;
    logic [7:0][9:0] levels;
    int fails, total_checks, n, irqs;
    logic [2:0] tcode [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h7};
    int tlen [8] = '{SAC_CONV_39, SAC_CONV_78, SAC_CONV_156, SAC_CONV_312,
        SAC_CONV_624, SAC_CONV_1248, SAC_CONV_1248, SAC_CONV_1248};

    sac_top sac_top_inst (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .deep_standby, .comparator_in, .sample_hold_en, .dac_code,
        .ladder_connect, .analog_in_enable, .analog_route, .conv_busy_flag, .conv_done_irq);
    sac_analog_model sac_analog_model_inst (.ref_clk, .rst, .sample_hold_en,
        .analog_route, .dac_code, .levels, .comparator_in);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Register port tasks.
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rx(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rx

    // Counts busy cycles and irq pulses of one conversion, with a bound.
    task automatic conv_wait(input int len);
        n = 0;
        irqs = 0;
        for (int k = 0; k < 3000; k++) begin
            @(posedge ref_clk);
            #1;
            if (conv_done_irq === 1'b1) irqs++;
            if (conv_busy_flag === 1'b1) n++;
            else if (n > 0) break;
        end
        if (n == 0 || conv_busy_flag !== 1'b0) begin
            $display("ERROR %0t: conversion wait timed out", $time);
            fails++;
            finish_test();
        end
        `CHK(n, len)
        `CHK(irqs, 1)
    endtask : conv_wait

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        deep_standby = 1'b0;
        fails = 0;
        total_checks = 0;
        levels = {10'h3fe, 10'h001, 10'h1ff, 10'h200, 10'h2aa, 10'h155, 10'h000, 10'h3ff};
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rx(SAC_ADDR_CONTROL, SAC_CONTROL_RESET);
        rx(SAC_ADDR_TIMING, {2'h0, SAC_TIMING_RESET});
        rx(8'h3c, 8'h00);
        `CHK(analog_in_enable, 1'b0)
        `CHK(ladder_connect, 1'b0)
        $display("reset test done");
        // Every channel and every time code, one software conversion each.
        for (int i = 0; i < 8; i++) begin
            wr(SAC_ADDR_TIMING, {2'h0, i[0], 1'b1, tcode[i], 1'b0});
            wr(SAC_ADDR_CONTROL, {4'ha, i[3:0]});
            conv_wait(tlen[i]);
            `CHK(analog_route, 8'(1 << i))
            `CHK(analog_in_enable, 1'b1)
            rx(SAC_ADDR_CONTROL, {4'h2, i[3:0]});
            rx(SAC_ADDR_RES_LOW, {levels[i][1:0], 2'b10, 4'h0});
            rx(SAC_ADDR_RES_HIGH, levels[i][9:2]);
            rx(SAC_ADDR_RES_LOW, {levels[i][1:0], 2'b00, 4'h0});
            `CHK(ladder_connect, i[0])
        end
        $display("sweep test done");
        // Repeat mode, then an abort whose partial result must not land.
        wr(SAC_ADDR_TIMING, 8'h10);
        wr(SAC_ADDR_CONTROL, 8'he1);
        conv_wait(SAC_CONV_39);
        @(posedge ref_clk);
        #1;
        `CHK(conv_busy_flag, 1'b1)
        conv_wait(SAC_CONV_39 - 1);
        levels[1] = 10'h155;
        repeat (20) @(posedge ref_clk);
        wr(SAC_ADDR_CONTROL, 8'h00);
        rx(SAC_ADDR_RES_HIGH, 8'h00);
        wr(SAC_ADDR_CONTROL, 8'hc1);
        wr(SAC_ADDR_CONTROL, 8'h00);
        wr(SAC_ADDR_CONTROL, 8'ha1);
        conv_wait(SAC_CONV_39);
        rx(SAC_ADDR_RES_LOW, 8'h60);
        rx(SAC_ADDR_RES_HIGH, 8'h55);
        $display("repeat test done");
        // Standby in mid-conversion clears controls and blocks writes.
        wr(SAC_ADDR_CONTROL, 8'ha2);
        repeat (10) @(posedge ref_clk);
        deep_standby <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(conv_busy_flag, 1'b0)
        wr(SAC_ADDR_CONTROL, 8'ha2);
        wr(SAC_ADDR_TIMING, 8'h3e);
        rx(SAC_ADDR_CONTROL, SAC_CONTROL_RESET);
        rx(SAC_ADDR_TIMING, {2'h0, SAC_TIMING_RESET});
        deep_standby <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        `CHK(conv_busy_flag, 1'b0)
        wr(SAC_ADDR_CONTROL, 8'h10);
        $display("standby test done");
        finish_test();
    end
endmodule : test_sar_adc_control
`default_nettype wire
